// ---- dv/cpmc_pwr_sva.sv ----
// assertion checker for the cpu power mode controller
`timescale 1ns/10ps
module cpmc_pwr_sva #(parameter NIRQ = 12, parameter NPER = 8) (
    // clock and reset
    input wire pclk, input wire presetn,
    // cpu requests
    input wire wait_for_interrupt_instr, input wire irq_take, input wire wake_reset,
    input wire instr_valid, input wire [7:0] instr_opcode, input wire [NIRQ-1:0] irq_pending,
    // controller outputs
    input wire cpu_stop, input wire fetch_en, input wire fetch_reset_vector, input wire irq_branch,
    input wire cc_push, input wire osc_on, input wire pll_on, input wire regulator_pd,
    input wire [NPER-1:0] periph_clk_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // cycles since the last reset wake request
    reg [9:0] since_rst_ff;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            since_rst_ff <= 10'h000;
        else if (wake_reset)
            since_rst_ff <= 10'h000;
        else if (since_rst_ff != 10'h3FF)
            since_rst_ff <= since_rst_ff + 10'h001;
    end
    wait_stop_a: assert property (
        wait_for_interrupt_instr && fetch_en |=> cpu_stop && osc_on) else $error("wait entry");
    halt_entry_a: assert property (
        instr_valid && instr_opcode == 8'h8E && fetch_en && (irq_pending & 12'h3F4) == 12'h000
        |-> ##[1:2] !osc_on) else $error("halt not entered");
    halt_quiet_a: assert property (
        !osc_on |-> !fetch_en && !pll_on && periph_clk_en == {NPER{1'b0}}) else $error("halt busy");
    reg_pd_halt_a: assert property (
        regulator_pd |-> !osc_on) else $error("regulator down outside halt");
    halt_hold_a: assert property (
        !osc_on && !wake_reset && !$past(wake_reset) && (irq_pending & 12'h3F4) == 12'h000
        |=> !osc_on) else $error("halt left without wake source");
    rst_delay_a: assert property (
        fetch_reset_vector |-> since_rst_ff >= 10'h200) else $error("reset fetch too early");
    rst_bound_a: assert property (
        wake_reset && cpu_stop |-> ##[512:600] fetch_reset_vector) else $error("no reset fetch");
    rst_lowpwr_a: assert property (
        fetch_reset_vector |-> !pll_on) else $error("pll on after reset wake");
    branch_cause_a: assert property (
        irq_branch |-> $past(irq_pending) != 12'h000) else $error("branch without interrupt");
    cc_push_a: assert property (
        irq_take && fetch_en |=> cc_push) else $error("no mask push");
    cover property (irq_branch);
    cover property (fetch_reset_vector);
    cover property (!osc_on ##1 osc_on);
endmodule // cpmc_pwr_sva

bind cpmc_power_ctrl cpmc_pwr_sva #(.NIRQ(NIRQ), .NPER(NPER)) u_cpmc_pwr_sva (
    .pclk(pclk), .presetn(presetn), .wait_for_interrupt_instr(wait_for_interrupt_instr),
    .irq_take(irq_take), .wake_reset(wake_reset), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .irq_pending(irq_pending), .cpu_stop(cpu_stop),
    .fetch_en(fetch_en), .fetch_reset_vector(fetch_reset_vector), .irq_branch(irq_branch),
    .cc_push(cc_push), .osc_on(osc_on), .pll_on(pll_on), .regulator_pd(regulator_pd),
    .periph_clk_en(periph_clk_en)
);

// ---- dv/tb.sv ----
// self-checking testbench for the cpu power mode controller
`timescale 1ns/10ps
`include "cpmc_consts.vh"
module tb;
    reg pclk, presetn, psel, penable, pwrite, instr_valid, wait_for_interrupt_instr;
    reg irq_take, cc_pop, wake_reset, pll_lock, err_seen;
    reg [11:0] paddr, irq_pending;
    reg [31:0] pwdata, rd;
    reg [7:0] instr_opcode;
    reg [3:0] irq_take_id;
    reg [1:0] cc_pop_mask;
    wire [31:0] prdata;
    wire [7:0] periph_clk_en;
    wire [1:0] cc_push_mask;
    wire pready, pslverr, cpu_stop, fetch_en, fetch_reset_vector, irq_branch, cc_push;
    wire osc_on, pll_on, usb_phy_power_off, slew_comp_off_bit, regulator_pd;
    integer err_count, checks_done, n, c, k;

    cpmc_power_ctrl u_cpmc_power_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instr_valid(instr_valid), .instr_opcode(instr_opcode),
        .wait_for_interrupt_instr(wait_for_interrupt_instr), .irq_take(irq_take),
        .irq_take_id(irq_take_id), .cc_pop(cc_pop), .cc_pop_mask(cc_pop_mask),
        .wake_reset(wake_reset), .irq_pending(irq_pending), .pll_lock(pll_lock),
        .cpu_stop(cpu_stop), .fetch_en(fetch_en), .fetch_reset_vector(fetch_reset_vector),
        .irq_branch(irq_branch), .cc_push(cc_push), .cc_push_mask(cc_push_mask),
        .osc_on(osc_on), .pll_on(pll_on), .periph_clk_en(periph_clk_en),
        .usb_phy_power_off(usb_phy_power_off), .slew_comp_off_bit(slew_comp_off_bit),
        .regulator_pd(regulator_pd)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task conclude;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            do begin
                @(posedge pclk);
                k = k + 1;
            end while (pready !== 1'b1 && k < 16);
            chk(pready, 1'b1);
            if (pready !== 1'b1)
                conclude;
            rd = prdata;
            err_seen = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task t_reset;
        begin
            chk({pll_on, osc_on, fetch_en, cpu_stop}, 4'h6);
            apb(1'b0, `CPMC_OFF_STAT, 32'h0000_0000);
            chk(rd, 32'h0000_0030);
            apb(1'b0, `CPMC_OFF_CCR, 32'h0000_0000);
            chk({rd[5], rd[3]}, `CPMC_PRIO_LEVEL3);
            apb(1'b0, 12'h040, 32'h0000_0000);
            chk(err_seen, 1'b1);
            instr_valid <= 1'b1;
            instr_opcode <= 8'h8F;
            @(posedge pclk);
            instr_valid <= 1'b0;
            repeat (2) @(posedge pclk);
            chk(osc_on, 1'b1);
            $display("reset test done");
        end
    endtask

    task t_ctrl;
        begin
            for (n = 3; n >= 0; n = n - 1) begin
                apb(1'b1, `CPMC_OFF_CTRL, n);
                @(posedge pclk);
                chk({slew_comp_off_bit, usb_phy_power_off}, n[1:0]);
            end
            $display("control test done");
        end
    endtask

    task t_prio;
        begin
            for (n = 0; n < 4; n = n + 1) begin
                apb(1'b1, `CPMC_OFF_PRIO, n << 10);
                irq_take <= 1'b1;
                @(posedge pclk);
                irq_take <= 1'b0;
                @(posedge pclk);
                chk({cc_push, cc_push_mask}, 3'h7);
                apb(1'b0, `CPMC_OFF_CCR, 32'h0000_0000);
                chk({rd[5], rd[3]}, n[1:0]);
                cc_pop <= 1'b1;
                @(posedge pclk);
                cc_pop <= 1'b0;
                apb(1'b0, `CPMC_OFF_CCR, 32'h0000_0000);
                chk({rd[5], rd[3]}, 2'h3);
            end
            $display("priority test done");
        end
    endtask

    task t_wait;
        begin
            apb(1'b1, `CPMC_OFF_CER, 32'h0000_005A);
            wait_for_interrupt_instr <= 1'b1;
            @(posedge pclk);
            wait_for_interrupt_instr <= 1'b0;
            @(posedge pclk);
            chk({cpu_stop, osc_on, periph_clk_en}, 10'h35A);
            apb(1'b0, `CPMC_OFF_CCR, 32'h0000_0000);
            chk({rd[5], rd[3]}, 2'h0);
            irq_pending <= 12'h400;
            for (k = 0; irq_branch !== 1'b1 && k < 8; k = k + 1)
                @(posedge pclk);
            chk(irq_branch, 1'b1);
            if (irq_branch !== 1'b1)
                conclude;
            irq_pending <= 12'h000;
            @(posedge pclk);
            chk({cpu_stop, fetch_en}, 2'h1);
            $display("wait test done");
        end
    endtask

    // m: 0 irq wake, 1 full power, 2 reset wake, 3 pending wake, 4 reset from wait
    task t_halt(input integer m);
        begin
            apb(1'b1, `CPMC_OFF_CTRL, (m == 1 || m == 2) ? 32'h0000_000C : 32'h0000_0004);
            irq_pending <= (m == 3) ? 12'h010 : (m == 4) ? 12'h000 : 12'h800;
            instr_valid <= (m != 4);
            wait_for_interrupt_instr <= (m == 4);
            instr_opcode <= `CPMC_HALT_OPCODE;
            @(posedge pclk);
            instr_valid <= 1'b0;
            wait_for_interrupt_instr <= 1'b0;
            repeat (20) @(posedge pclk);
            if (m == 3) begin
                chk(osc_on, 1'b1);
                irq_pending <= 12'h000;
                apb(1'b0, `CPMC_OFF_CCR, 32'h0000_0000);
                chk({rd[5], rd[3]}, 2'h0);
            end else begin
                chk({osc_on, regulator_pd, periph_clk_en}, (m == 4) ? 10'h25A : 10'h100);
                if (m == 2 || m == 4)
                    wake_reset <= 1'b1;
                else
                    irq_pending <= 12'h810;
                @(posedge pclk);
                wake_reset <= 1'b0;
                if (m == 1) begin
                    repeat (700) @(posedge pclk);
                    chk(fetch_en, 1'b0);
                    pll_lock <= 1'b1;
                end
                for (c = 1; fetch_en !== 1'b1 && c < 900; c = c + 1)
                    @(posedge pclk);
                chk(fetch_en, 1'b1);
                if (fetch_en !== 1'b1)
                    conclude;
                chk(c >= 512 || m == 1, 1'b1);
                chk(pll_on, m == 1);
                chk(fetch_reset_vector, m == 2 || m == 4);
                if (m < 2)
                    chk(periph_clk_en, 8'h5A);
                @(posedge pclk);
                chk(pll_on, m == 1);
                irq_pending <= 12'h000;
                pll_lock <= 1'b0;
            end
            apb(1'b1, `CPMC_OFF_CTRL, 32'h0000_0000);
            $display("low power test %0d done", m);
        end
    endtask

    initial begin
        err_count = 0;
        checks_done = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, instr_valid, wait_for_interrupt_instr} = 5'h00;
        {irq_take, cc_pop, wake_reset, pll_lock} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        instr_opcode = 8'h00;
        irq_take_id = 4'h5;
        cc_pop_mask = 2'h3;
        irq_pending = 12'h000;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_ctrl;
        t_prio;
        t_wait;
        for (n = 0; n < 5; n = n + 1)
            t_halt(n);
        conclude;
    end
endmodule // tb

// ---- hw/cpmc_power_ctrl.v ----
// cpu power mode controller with apb registers
// Overview of operation
// - reset enters low power, pll off
// - usb phy off bit unpowers phy
// - wait stops cpu only
// - wait forces interrupt masks to zero
// - wait until interrupt or reset; branch
// - reset from wait: 512 cycle delay
// - push cc, load priority, restore on pop
// - halt stops oscillator and peripherals
// - regulator off bit powers down in halt
// - comp off bit stops slew cell
// - halt clears masks; pending wake exits
// - only reset or wake-capable irq wakes
// - reset wake: osc on, 512, low power
// - irq wake: 512 then pll lock if full
// - opcode 0x8E decodes as halt
// - peripheral clocks restored after halt
// - mask encoding 10,01,00,11 levels
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/10ps
`include "cpmc_consts.vh"
module cpmc_power_ctrl #(
    parameter NIRQ = `CPMC_NUM_IRQ,
    parameter NPER = 8
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // cpu interface
    input wire instr_valid,
    input wire [7:0] instr_opcode,
    input wire wait_for_interrupt_instr,
    input wire irq_take,
    input wire [3:0] irq_take_id,
    input wire cc_pop,
    input wire [1:0] cc_pop_mask,
    input wire wake_reset,
    input wire [NIRQ-1:0] irq_pending,
    input wire pll_lock,
    // cpu and clock outputs
    output reg cpu_stop,
    output reg fetch_en,
    output reg fetch_reset_vector,
    output reg irq_branch,
    output reg cc_push,
    output reg [1:0] cc_push_mask,
    output reg osc_on,
    output reg pll_on,
    output reg [NPER-1:0] periph_clk_en,
    output reg usb_phy_power_off,
    output reg slew_comp_off_bit,
    output reg regulator_pd
);
    // ****************************************
    // states
    // ****************************************
    localparam ST_RUN = 3'd0;
    localparam ST_WAIT = 3'd1;
    localparam ST_HALT = 3'd2;
    localparam ST_STAB = 3'd3;
    localparam ST_LOCK = 3'd4;

    reg [2:0] state_ff, nxt_state;
    reg [7:0] ctrl_ff;
    reg [7:0] condition_code_reg_ff;
    reg [1:0] irq_soft_priority_regs_ff [0:NIRQ-1];
    reg [NPER-1:0] periph_clock_enable_reg_ff;
    reg [NIRQ-1:0] wake_map_ff;
    reg by_reset_ff;
    reg stab_start_ff;
    wire stab_done;
    wire any_irq;
    wire any_wake;
    wire is_halt;
    wire apb_wr;
    wire apb_rd;
    wire full_power;
    integer k;

    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & ~pwrite;
    assign full_power = ctrl_ff[`CPMC_CTRL_FULL_POWER];
    assign is_halt = instr_valid & (instr_opcode == `CPMC_HALT_OPCODE);

    cpmc_wake_filter #(.N(NIRQ)) u_filter (
        .irq_pending(irq_pending),
        .wake_map(wake_map_ff),
        .any_irq(any_irq),
        .any_wake(any_wake)
    );

    cpmc_wake_counter #(.CYCLES(`CPMC_STAB_CYCLES), .WIDTH(10)) u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .start(stab_start_ff),
        .osc_on(osc_on),
        .done(stab_done)
    );

    // ****************************************
    // mode sequencing
    // ****************************************
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (wait_for_interrupt_instr) begin
                    nxt_state = ST_WAIT;
                end else if (is_halt) begin
                    nxt_state = any_wake ? ST_RUN : ST_HALT;
                end
            end
            // leave wait on irq or reset
            ST_WAIT: begin
                if (wake_reset) begin
                    nxt_state = ST_STAB;
                end else if (any_irq) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_HALT: begin
                if (wake_reset || any_wake) begin
                    nxt_state = ST_STAB;
                end
            end
            ST_STAB: begin
                if (stab_done) begin
                    nxt_state = (full_power && !by_reset_ff) ? ST_LOCK : ST_RUN;
                end
            end
            ST_LOCK: begin
                if (pll_lock) begin
                    nxt_state = ST_RUN;
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // low power, pll off at reset
            state_ff <= ST_RUN;
            by_reset_ff <= 1'b0;
            stab_start_ff <= 1'b0;
            cpu_stop <= 1'b0;
            fetch_en <= 1'b1;
            fetch_reset_vector <= 1'b0;
            irq_branch <= 1'b0;
            osc_on <= 1'b1;
            pll_on <= 1'b0;
            periph_clk_en <= {NPER{1'b0}};
            regulator_pd <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            stab_start_ff <= (nxt_state == ST_STAB) && (state_ff != ST_STAB);
            if (nxt_state == ST_STAB && state_ff != ST_STAB) begin
                by_reset_ff <= wake_reset;
            end
            cpu_stop <= (nxt_state != ST_RUN);
            fetch_en <= (nxt_state == ST_RUN);
            fetch_reset_vector <= (nxt_state == ST_RUN) && by_reset_ff &&
                ((state_ff == ST_STAB) || (state_ff == ST_LOCK));
            irq_branch <= (state_ff == ST_WAIT) && (nxt_state == ST_RUN);
            osc_on <= (nxt_state != ST_HALT);
            pll_on <= full_power && (nxt_state != ST_HALT) &&
                !(by_reset_ff && state_ff == ST_STAB);
            periph_clk_en <= (nxt_state == ST_HALT || nxt_state == ST_STAB ||
                nxt_state == ST_LOCK) ? {NPER{1'b0}} : periph_clock_enable_reg_ff;
            regulator_pd <= (nxt_state == ST_HALT) && ctrl_ff[`CPMC_CTRL_REG_OFF];
        end
    end

    // ****************************************
    // registers and interrupt masks
    // ****************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 8'h00;
            condition_code_reg_ff <= `CPMC_CC_RESET;
            periph_clock_enable_reg_ff <= {NPER{1'b1}};
            wake_map_ff <= `CPMC_WAKE_MAP_RST;
            for (k = 0; k < NIRQ; k = k + 1) begin
                irq_soft_priority_regs_ff[k] <= `CPMC_PRIO_LEVEL3;
            end
            cc_push <= 1'b0;
            cc_push_mask <= 2'b00;
            usb_phy_power_off <= 1'b0;
            slew_comp_off_bit <= 1'b0;
        end else begin
            cc_push <= 1'b0;
            usb_phy_power_off <= ctrl_ff[`CPMC_CTRL_USB_PHY_OFF];
            slew_comp_off_bit <= ctrl_ff[`CPMC_CTRL_SLEW_COMP_OFF];
            if (apb_wr) begin
                case (paddr)
                    `CPMC_OFF_CTRL: ctrl_ff <= pwdata[7:0];
                    `CPMC_OFF_CCR: condition_code_reg_ff <= pwdata[7:0];
                    `CPMC_OFF_PRIO: begin
                        for (k = 0; k < NIRQ; k = k + 1) begin
                            irq_soft_priority_regs_ff[k] <= pwdata[2*k +: 2];
                        end
                    end
                    `CPMC_OFF_CER: periph_clock_enable_reg_ff <= pwdata[NPER-1:0];
                    `CPMC_OFF_WAKE: wake_map_ff <= pwdata[NIRQ-1:0];
                    default: ;
                endcase
            end
            if (state_ff == ST_STAB && stab_done && by_reset_ff) begin
                ctrl_ff[`CPMC_CTRL_FULL_POWER] <= 1'b0;
            end
            // wait forces masks to level 2
            if (nxt_state == ST_WAIT || (state_ff == ST_RUN && is_halt)) begin
                condition_code_reg_ff[`CPMC_CC_MASK_HIGH] <= 1'b0;
                condition_code_reg_ff[`CPMC_CC_MASK_LOW] <= 1'b0;
            end
            if (irq_take) begin
                cc_push <= 1'b1;
                cc_push_mask <= {condition_code_reg_ff[`CPMC_CC_MASK_HIGH],
                    condition_code_reg_ff[`CPMC_CC_MASK_LOW]};
                condition_code_reg_ff[`CPMC_CC_MASK_HIGH] <=
                    irq_soft_priority_regs_ff[irq_take_id][1];
                condition_code_reg_ff[`CPMC_CC_MASK_LOW] <=
                    irq_soft_priority_regs_ff[irq_take_id][0];
            end else if (cc_pop) begin
                condition_code_reg_ff[`CPMC_CC_MASK_HIGH] <= cc_pop_mask[1];
                condition_code_reg_ff[`CPMC_CC_MASK_LOW] <= cc_pop_mask[0];
            end
        end
    end

    // ****************************************
    // apb read and handshake
    // ****************************************
    reg [31:0] prio_word;
    integer j;
    always @* begin
        prio_word = 32'h0000_0000;
        for (j = 0; j < NIRQ; j = j + 1) begin
            prio_word[2*j +: 2] = irq_soft_priority_regs_ff[j];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    `CPMC_OFF_CTRL: prdata <= {24'h00_0000, ctrl_ff};
                    `CPMC_OFF_STAT: prdata <= {25'h000_0000, pll_on, osc_on,
                        fetch_en, 1'b0, state_ff};
                    `CPMC_OFF_CCR: prdata <= {24'h00_0000, condition_code_reg_ff};
                    `CPMC_OFF_PRIO: prdata <= prio_word;
                    `CPMC_OFF_CER: prdata[NPER-1:0] <= periph_clock_enable_reg_ff;
                    `CPMC_OFF_WAKE: prdata[NIRQ-1:0] <= wake_map_ff;
                    default: pslverr <= apb_rd | pwrite;
                endcase
            end
        end
    end
endmodule // cpmc_power_ctrl

// ---- hw/cpmc_wake_counter.v ----
// oscillator stabilisation counter
`timescale 1ns/10ps
`include "cpmc_consts.vh"
module cpmc_wake_counter #(
    parameter CYCLES = `CPMC_STAB_CYCLES,
    parameter WIDTH = 10
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire start,
    input wire osc_on,
    // status
    output reg done
);
    localparam [31:0] LAST = CYCLES - 1;
    reg [WIDTH-1:0] cnt_ff;
    reg run_ff;

    // counts only while the oscillator runs; done is a one-cycle pulse
    // so a stale done cannot end the next stabilisation at once
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= {WIDTH{1'b0}};
            run_ff <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt_ff <= {WIDTH{1'b0}};
                run_ff <= 1'b1;
            end else if (run_ff && osc_on) begin
                if (cnt_ff == LAST[WIDTH-1:0]) begin
                    run_ff <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // cpmc_wake_counter

// ---- hw/cpmc_wake_filter.v ----
// wake-capable interrupt filter
`timescale 1ns/10ps
module cpmc_wake_filter #(
    parameter N = 12
) (
    // inputs
    input wire [N-1:0] irq_pending,
    input wire [N-1:0] wake_map,
    // outputs
    output wire any_irq,
    output wire any_wake
);
    wire [N-1:0] hit;
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_src
            assign hit[i] = irq_pending[i] & wake_map[i];
        end
    endgenerate
    assign any_irq = |irq_pending;
    assign any_wake = |hit;
endmodule // cpmc_wake_filter

// ---- pkg/cpmc_consts.vh ----
// constants for the cpu power mode controller
`ifndef CPMC_CONSTS_VH
`define CPMC_CONSTS_VH
// apb register byte offsets
`define CPMC_OFF_CTRL 12'h000
`define CPMC_OFF_STAT 12'h004
`define CPMC_OFF_CCR 12'h008
`define CPMC_OFF_PRIO 12'h00C
`define CPMC_OFF_CER 12'h010
`define CPMC_OFF_WAKE 12'h014
// control register fields
`define CPMC_CTRL_USB_PHY_OFF 0
`define CPMC_CTRL_SLEW_COMP_OFF 1
`define CPMC_CTRL_REG_OFF 2
`define CPMC_CTRL_FULL_POWER 3
// status register fields
`define CPMC_STAT_MODE_LSB 0
`define CPMC_STAT_FETCH_EN 4
`define CPMC_STAT_OSC_ON 5
`define CPMC_STAT_PLL_ON 6
// condition code mask bit positions
`define CPMC_CC_MASK_HIGH 5
`define CPMC_CC_MASK_LOW 3
// interrupt mask encodings (high, low)
`define CPMC_PRIO_LEVEL0 2'b10
`define CPMC_PRIO_LEVEL1 2'b01
`define CPMC_PRIO_LEVEL2 2'b00
`define CPMC_PRIO_LEVEL3 2'b11
// condition code reset value
`define CPMC_CC_RESET 8'hE8
// halt opcode
`define CPMC_HALT_OPCODE 8'h8E
// stabilisation delay in cpu cycles
`define CPMC_STAB_CYCLES 512
// interrupt sources and default wake map
`define CPMC_NUM_IRQ 12
`define CPMC_WAKE_MAP_RST 12'h3F4
`endif
